// *** design/lps_pkg.sv ***
// lps_pkg: shared types and constants for the per-port link power control
// assumes a single 40 MHz core clock domain and three switch ports
package lps_pkg;

  localparam int NUM_PORTS   = 3;
  localparam int NUM_LANES   = 4;
  localparam int UP_PORT     = 0;
  localparam int SYNC_STAGES = 2;

  // timing of the fundamental reset hold
  localparam int CLK_MHZ         = 40;
  localparam int PERST_HOLD_MS   = 100;
  localparam int PERST_HOLD_CYC  = PERST_HOLD_MS * 1000 * CLK_MHZ;
  localparam int HOLD_CNT_W      = 23;

  // reset values
  localparam logic FUNC_RST_RST   = 1'b1;
  localparam logic CLKREQ_OE_RST  = 1'b0;
  localparam logic CLKREQ_OUT_VAL = 1'b0;

  typedef enum logic [2:0] {
    LPS_LINK_L0,
    LPS_LINK_L0S,
    LPS_LINK_L1,
    LPS_LINK_L2L3_RDY,
    LPS_LINK_L3
  } lps_link_t;

  typedef enum logic [2:0] {
    LPS_D0,
    LPS_D1,
    LPS_D2,
    LPS_D3_HOT,
    LPS_D3_COLD
  } lps_dstate_t;

  // per-port inputs from the port's link layer and configuration space
  typedef struct packed {
    lps_link_t   link;
    lps_dstate_t dstate;
    logic        aspm_en;
    logic        l11_en;
  } lps_port_in_t;

  // per-port power controls towards the analog front end
  typedef struct packed {
    logic in_l11;
    logic pll_off;
    logic rxbuf_off;
  } lps_port_pwr_t;

  // per-port status reported back to the core
  typedef struct packed {
    lps_link_t   link;
    lps_dstate_t dstate;
    logic        aspm_active;
    logic        in_l11;
  } lps_port_stat_t;

endpackage

// *** design/lps_port_substate.sv ***
// lps_port_substate: L1 / L1.1 sub-state machine for one switch port
// assumes clkreq_asserted is already synchronised to core_clk
`timescale 1ns/1ps
module lps_port_substate
  import lps_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic          func_rst,
  input  wire logic          link_in_l1,
  input  wire logic          l11_en,
  input  wire logic          clkreq_asserted,
  output lps_port_pwr_t      pwr
);

  typedef enum logic [1:0] {
    SS_OUT,
    SS_L1,
    SS_L11
  } lps_ss_t;

  lps_ss_t state_r;
  lps_ss_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SS_OUT: begin
        if (link_in_l1) begin
          state_nxt = SS_L1;
        end
      end
      SS_L1: begin
        if (!link_in_l1) begin
          state_nxt = SS_OUT;
        end else if (clkreq_asserted && l11_en) begin
          state_nxt = SS_L11;
        end
      end
      SS_L11: begin
        if (!clkreq_asserted || !link_in_l1) begin
          state_nxt = SS_L1;
        end
      end
      default: state_nxt = SS_OUT;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || func_rst) begin
      state_r <= SS_OUT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // front-end power stays off only while in the sub-state
  assign pwr.in_l11    = (state_r == SS_L11);
  assign pwr.pll_off   = (state_r == SS_L11);
  assign pwr.rxbuf_off = (state_r == SS_L11);

endmodule // lps_port_substate

// *** design/lps_power_ctrl.sv ***
// lps_power_ctrl: link power control for a three-port switch
// assumes pins (fundamental reset, clock requests, buffer power-down) are asynchronous
// and link/lane state inputs come from logic on core_clk
`timescale 1ns/1ps
module lps_power_ctrl
  import lps_pkg::*;
#(
  parameter int unsigned HOLD_CYC = PERST_HOLD_CYC
)
(
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 perst_n,
  input  wire logic                 refclk_buffer_powerdown,
  input  wire logic [NUM_PORTS-1:0] clkreq_n_i,
  input  wire lps_port_in_t [NUM_PORTS-1:0] port_in,
  input  wire logic [NUM_LANES-1:0] lane_in_l11,
  output logic                      clkreq_up_o,
  output logic                      clkreq_up_oe,
  output logic                      func_rst,
  output logic [NUM_PORTS-1:0]      refclk_out_en,
  output logic [NUM_PORTS-1:0]      port_pll_off,
  output logic [NUM_PORTS-1:0]      port_rxbuf_off,
  output logic                      shared_pll_off,
  output lps_port_stat_t [NUM_PORTS-1:0] port_stat
);

  // two-stage synchronisers for every pin input
  logic [NUM_PORTS-1:0] clkreq_n_s1_r;
  logic [NUM_PORTS-1:0] clkreq_n_s2_r;
  logic                 perst_n_s1_r;
  logic                 perst_n_s2_r;
  logic                 bufpd_s1_r;
  logic                 bufpd_s2_r;
  logic [NUM_PORTS-1:0] clkreq_n_s1_nxt;
  logic [NUM_PORTS-1:0] clkreq_n_s2_nxt;
  logic                 perst_n_s1_nxt;
  logic                 perst_n_s2_nxt;
  logic                 bufpd_s1_nxt;
  logic                 bufpd_s2_nxt;

  // only the second stage is read by logic; the first may still be settling
  always_comb begin
    clkreq_n_s1_nxt = clkreq_n_i;
    clkreq_n_s2_nxt = clkreq_n_s1_r;
    perst_n_s1_nxt  = perst_n;
    perst_n_s2_nxt  = perst_n_s1_r;
    bufpd_s1_nxt    = refclk_buffer_powerdown;
    bufpd_s2_nxt    = bufpd_s1_r;
  end

  // request pins reset to their released level so no false request follows reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      clkreq_n_s1_r <= '1;
      clkreq_n_s2_r <= '1;
      perst_n_s1_r  <= 1'b0;
      perst_n_s2_r  <= 1'b0;
      bufpd_s1_r    <= 1'b1;
      bufpd_s2_r    <= 1'b1;
    end else begin
      clkreq_n_s1_r <= clkreq_n_s1_nxt;
      clkreq_n_s2_r <= clkreq_n_s2_nxt;
      perst_n_s1_r  <= perst_n_s1_nxt;
      perst_n_s2_r  <= perst_n_s2_nxt;
      bufpd_s1_r    <= bufpd_s1_nxt;
      bufpd_s2_r    <= bufpd_s2_nxt;
    end
  end

  function automatic logic req_asserted(input logic req_n);
    return ~req_n;
  endfunction

  function automatic logic link_is_l1(input lps_link_t link);
    return (link == LPS_LINK_L1);
  endfunction

  // active-state power management counts only L0s and L1 as low power
  function automatic logic aspm_state(input lps_link_t link);
    return (link == LPS_LINK_L0S) || link_is_l1(link);
  endfunction

  // decoded once so every consumer sees the same synchronised request
  logic [NUM_PORTS-1:0] req_s;

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      req_s[p] = req_asserted(clkreq_n_s2_r[p]);
    end
  end

  // fundamental reset hold: functions stay in reset while the pin is low,
  // and a guard counter, run once from sys_rst, covers only a release within HOLD_CYC cycles of it
  logic [HOLD_CNT_W-1:0] hold_cnt_r;
  logic [HOLD_CNT_W-1:0] hold_cnt_nxt;
  logic                  func_rst_r;
  logic                  func_rst_nxt;
  logic                  hold_done;

  assign hold_done = (hold_cnt_r >= HOLD_CYC[HOLD_CNT_W-1:0]);

  always_comb begin
    hold_cnt_nxt = hold_cnt_r;
    if (!hold_done) begin
      hold_cnt_nxt = hold_cnt_r + 1'b1;
    end
    func_rst_nxt = !perst_n_s2_r || !hold_done;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hold_cnt_r <= '0;
      func_rst_r <= FUNC_RST_RST;
    end else begin
      hold_cnt_r <= hold_cnt_nxt;
      func_rst_r <= func_rst_nxt;
    end
  end

  // per-port sub-state machines
  lps_port_pwr_t [NUM_PORTS-1:0] pwr;

  // ports leave L1.1 on their own; only the shared PLL waits for all of them
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    lps_port_substate i_lps_port_substate (
      .core_clk        (core_clk),
      .sys_rst         (sys_rst),
      .func_rst        (func_rst_r),
      .link_in_l1      (link_is_l1(port_in[p].link)),
      .l11_en          (port_in[p].l11_en),
      .clkreq_asserted (req_s[p]),
      .pwr             (pwr[p])
    );
  end

  // registered outputs
  logic                  clkreq_up_oe_nxt;
  logic [NUM_PORTS-1:0]  refclk_en_nxt;
  logic [NUM_PORTS-1:0]  pll_off_nxt;
  logic [NUM_PORTS-1:0]  rxbuf_off_nxt;
  logic                  shared_off_nxt;
  lps_port_stat_t [NUM_PORTS-1:0] stat_nxt;

  logic                  clkreq_up_oe_r;
  logic                  clkreq_up_o_r;
  logic [NUM_PORTS-1:0]  refclk_en_r;
  logic [NUM_PORTS-1:0]  pll_off_r;
  logic [NUM_PORTS-1:0]  rxbuf_off_r;
  logic                  shared_off_r;
  lps_port_stat_t [NUM_PORTS-1:0] stat_r;

  always_comb begin
    clkreq_up_oe_nxt = 1'b0;
    shared_off_nxt   = &lane_in_l11;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (p != UP_PORT && req_s[p]) begin
        clkreq_up_oe_nxt = 1'b1;
      end
      shared_off_nxt   = shared_off_nxt && pwr[p].in_l11;
      pll_off_nxt[p]   = pwr[p].pll_off;
      rxbuf_off_nxt[p] = pwr[p].rxbuf_off;
      // clock is needed when requested or while the port is outside L1.1
      refclk_en_nxt[p] = !bufpd_s2_r &&
                         (req_s[p] || !pwr[p].in_l11);
      stat_nxt[p].link        = port_in[p].link;
      stat_nxt[p].dstate      = port_in[p].dstate;
      stat_nxt[p].aspm_active = port_in[p].aspm_en &&
                                aspm_state(port_in[p].link);
      stat_nxt[p].in_l11      = pwr[p].in_l11;
    end
    if (func_rst_r) begin
      // the shared PLL stays on and no clock is requested upstream while held in reset
      clkreq_up_oe_nxt = 1'b0;
      shared_off_nxt   = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      clkreq_up_oe_r <= CLKREQ_OE_RST;
      clkreq_up_o_r  <= CLKREQ_OUT_VAL;
      refclk_en_r    <= '0;
      pll_off_r      <= '0;
      rxbuf_off_r    <= '0;
      shared_off_r   <= 1'b0;
      stat_r         <= '0;
    end else begin
      clkreq_up_oe_r <= clkreq_up_oe_nxt;
      clkreq_up_o_r  <= CLKREQ_OUT_VAL;
      refclk_en_r    <= refclk_en_nxt;
      pll_off_r      <= pll_off_nxt;
      rxbuf_off_r    <= rxbuf_off_nxt;
      shared_off_r   <= shared_off_nxt;
      stat_r         <= stat_nxt;
    end
  end

  // open-drain upstream request: only ever pulls low, pull-up releases it
  assign clkreq_up_o    = clkreq_up_o_r;
  assign clkreq_up_oe   = clkreq_up_oe_r;
  assign func_rst       = func_rst_r;
  assign refclk_out_en  = refclk_en_r;
  assign port_pll_off   = pll_off_r;
  assign port_rxbuf_off = rxbuf_off_r;
  assign shared_pll_off = shared_off_r;
  assign port_stat      = stat_r;

endmodule // lps_power_ctrl

// *** bench/lps_power_ctrl_asserts.sv ***
// lps_power_ctrl_chk: port assertions for the link power control
// assumes it is bound to lps_power_ctrl, one core clock
`timescale 1ns/1ps
module lps_power_ctrl_chk
  import lps_pkg::*;
#(
  parameter int unsigned HOLD_CYC = 16
)
(
  input wire logic                           core_clk,
  input wire logic                           sys_rst,
  input wire logic                           perst_n,
  input wire logic [NUM_PORTS-1:0]           clkreq_n_i,
  input wire lps_port_in_t [NUM_PORTS-1:0]   port_in,
  input wire logic [NUM_LANES-1:0]           lane_in_l11,
  input wire logic                           clkreq_up_oe,
  input wire logic                           func_rst,
  input wire logic [NUM_PORTS-1:0]           port_pll_off,
  input wire logic [NUM_PORTS-1:0]           port_rxbuf_off,
  input wire logic                           shared_pll_off,
  input wire lps_port_stat_t [NUM_PORTS-1:0] port_stat
);
  int unsigned cnt_r;
  int unsigned cnt_nxt;
  // saturates so a long run cannot wrap back under the hold count
  always_comb cnt_nxt = (cnt_r < HOLD_CYC) ? cnt_r + 1 : cnt_r;
  always_ff @(posedge core_clk) cnt_r <= sys_rst ? 0 : cnt_nxt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_pair; port_pll_off == port_rxbuf_off; endproperty
  a_pair: assert property (p_pair) else $error("pll rx differ");
  property p_stat; {port_stat[2].in_l11, port_stat[1].in_l11, port_stat[0].in_l11} == port_pll_off; endproperty
  a_stat: assert property (p_stat) else $error("status differs");
  property p_shared; shared_pll_off |-> (&$past(lane_in_l11)) && (&port_pll_off); endproperty
  a_shared: assert property (p_shared) else $error("shared pll off early");
  property p_oe; (perst_n && !func_rst && !clkreq_n_i[1]) [*5] |-> clkreq_up_oe; endproperty
  a_oe: assert property (p_oe) else $error("request not passed up");
  property p_hold; cnt_r < HOLD_CYC |-> func_rst; endproperty
  a_hold: assert property (p_hold) else $error("reset released early");
  property p_perst; !perst_n [*4] |-> func_rst; endproperty
  a_perst: assert property (p_perst) else $error("reset not held");
  // an unsynchronised pin would reach the output on the next edge
  property p_sync; $fell(clkreq_n_i[1]) && clkreq_n_i[2] && $past(clkreq_n_i[2]) && !clkreq_up_oe |=> !clkreq_up_oe;
  endproperty
  a_sync: assert property (p_sync) else $error("pin used raw");
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    property p_entry; $rose(port_pll_off[p]) |-> $past(port_in[p].link, 2) == LPS_LINK_L1 && $past(port_in[p].l11_en, 2);
    endproperty
    a_entry: assert property (p_entry) else $error("entry not from L1");
    property p_exit; clkreq_n_i[p] [*6] |-> !port_pll_off[p]; endproperty
    a_exit: assert property (p_exit) else $error("no exit");
  end
  cover property (shared_pll_off);
  cover property ($rose(port_pll_off[1]));
  cover property ($rose(clkreq_up_oe));
endmodule // lps_power_ctrl_chk

// *** bench/lps_link_partner.sv ***
// lps_link_partner: host and endpoint request wires with pull-ups
// assumes requests come from the bench on core_clk
`timescale 1ns/1ps
module lps_link_partner
  import lps_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 slow,
  input  wire logic [NUM_PORTS-1:0] req,
  input  wire logic                 clkreq_up_oe,
  output logic [NUM_PORTS-1:0]      clkreq_n
);
  logic [NUM_PORTS-1:0] req_r;
  // a slow partner answers one cycle late
  always_ff @(posedge core_clk) req_r <= req;
  // released wires float high through the pull-ups
  assign clkreq_n = ~((slow ? req_r : req) | {2'b00, clkreq_up_oe});
endmodule // lps_link_partner

// *** bench/lps_power_ctrl_tb.sv ***
// lps_power_ctrl_tb: directed self-checking bench
// assumes lps_link_partner drives the request wires
`timescale 1ns/1ps
module lps_power_ctrl_tb;
  import lps_pkg::*;
  localparam int unsigned HOLD_CYC = 16;
  logic core_clk, sys_rst, perst_n, refclk_buffer_powerdown, slow, clkreq_up_o, clkreq_up_oe, func_rst, shared_pll_off;
  logic [NUM_PORTS-1:0] req, clkreq_n_i, refclk_out_en, port_pll_off, port_rxbuf_off;
  logic [NUM_LANES-1:0] lane_in_l11;
  lps_port_in_t [NUM_PORTS-1:0] port_in;
  lps_port_stat_t [NUM_PORTS-1:0] port_stat;
  int miscompares, cmp_count, cycles;
  lps_power_ctrl #(.HOLD_CYC(HOLD_CYC)) i_lps_power_ctrl (.core_clk, .sys_rst, .perst_n, .refclk_buffer_powerdown,
    .clkreq_n_i, .port_in, .lane_in_l11, .clkreq_up_o, .clkreq_up_oe, .func_rst, .refclk_out_en, .port_pll_off,
    .port_rxbuf_off, .shared_pll_off, .port_stat);
  lps_link_partner i_lps_link_partner (.core_clk, .slow, .req, .clkreq_up_oe, .clkreq_n(clkreq_n_i));
  task automatic chk(string name, logic [2:0] seen, logic [2:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic complete_run();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic t_hold();
    cyc(HOLD_CYC + 8);
    chk("hold", {func_rst, shared_pll_off, clkreq_up_oe}, 3'b100);
    perst_n <= 1'b1;
    cyc(8);
    chk("run", {func_rst, clkreq_up_o, port_pll_off[0]}, 3'b000);
  endtask
  task automatic t_stat();
    for (int i = 0; i < 5; i++) begin
      port_in[0] <= '{lps_link_t'(i), lps_dstate_t'(i), 1'b1, 1'b0};
      cyc(3);
      chk("link", port_stat[0].link, lps_link_t'(i));
      chk("dst", port_stat[0].dstate, lps_dstate_t'(i));
      chk("aspm", {2'b00, port_stat[0].aspm_active}, {2'b00, i == 1 || i == 2});
    end
  endtask
  task automatic t_l11(logic s);
    slow <= s;
    port_in[1] <= '{LPS_LINK_L1, LPS_D0, 1'b1, 1'b1};
    port_in[2] <= '{LPS_LINK_L0, LPS_D0, 1'b1, 1'b1};
    port_in[0] <= '{LPS_LINK_L1, LPS_D0, 1'b1, 1'b0};
    // port 2 requests a cycle later so one pin falls alone
    req <= 3'b010;
    cyc(1);
    req <= 3'b110;
    cyc(8);
    chk("in", port_pll_off | port_rxbuf_off, 3'b010);
    chk("stat", {port_stat[2].in_l11, port_stat[1].in_l11, refclk_out_en[1]}, 3'b011);
    chk("up", {clkreq_up_o, clkreq_up_oe, clkreq_n_i[0]}, 3'b010);
    req <= 3'b000;
    cyc(8);
    chk("out", {port_pll_off[1], port_stat[1].in_l11, clkreq_up_oe}, 3'b000);
  endtask
  task automatic t_all();
    port_in <= {3{lps_port_in_t'{LPS_LINK_L1, LPS_D0, 1'b1, 1'b1}}};
    req <= 3'b111;
    lane_in_l11 <= 4'hF;
    cyc(8);
    chk("all", {shared_pll_off, port_pll_off[2], port_rxbuf_off[0]}, 3'b111);
    refclk_buffer_powerdown <= 1'b1;
    lane_in_l11 <= 4'h7;
    cyc(5);
    chk("lane", {shared_pll_off, refclk_out_en[1:0]}, 3'b000);
    refclk_buffer_powerdown <= 1'b0;
    lane_in_l11 <= 4'hF;
    cyc(5);
    chk("again", {shared_pll_off, refclk_out_en[1:0]}, 3'b111);
    perst_n <= 1'b0;
    cyc(6);
    chk("perst", {func_rst, shared_pll_off, port_pll_off[1]}, 3'b100);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // far longer than the directed sequence needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    sys_rst = 1'b1;
    perst_n = 1'b0;
    refclk_buffer_powerdown = 1'b0;
    slow = 1'b0;
    req = '0;
    port_in = '0;
    lane_in_l11 = '0;
    cycles = 0;
    miscompares = 0;
    cmp_count = 0;
    cyc(3);
    sys_rst <= 1'b0;
    t_hold();
    t_stat();
    t_l11(1'b0);
    t_l11(1'b1);
    t_all();
    complete_run();
  end
endmodule // lps_power_ctrl_tb
bind lps_power_ctrl lps_power_ctrl_chk #(.HOLD_CYC(HOLD_CYC)) i_lps_power_ctrl_chk (.core_clk, .sys_rst, .perst_n,
  .clkreq_n_i, .port_in, .lane_in_l11, .clkreq_up_oe, .func_rst, .port_pll_off, .port_rxbuf_off, .shared_pll_off,
  .port_stat);
